// ### fds_consts.vh
// constants for the front-end and dispatch event selector
`ifndef FDS_CONSTS_VH
`define FDS_CONSTS_VH

// register byte offsets
`define FDS_OFS_SELECT 8'h00
`define FDS_OFS_COUNT 8'h04
`define FDS_OFS_STATUS 8'h08

// select register fields
`define FDS_SEL_EVT_LSB 0
`define FDS_SEL_EVT_MSB 7
`define FDS_SEL_UMASK_LSB 8
`define FDS_SEL_UMASK_MSB 15
`define FDS_SEL_THR_LSB 16
`define FDS_SEL_THR_MSB 19
`define FDS_SEL_EDGE_BIT 20
`define FDS_SEL_NEG_BIT 21
`define FDS_SEL_EN_BIT 22
`define FDS_SEL_USED_MSB 22

// status register fields
`define FDS_ST_MATCH_BIT 0
`define FDS_ST_COND_BIT 1
`define FDS_ST_CNT_LSB 4
`define FDS_ST_CNT_MSB 7

// reset values
`define FDS_SELECT_RST 23'h00_0000
`define FDS_COUNT_RST 32'h0000_0000

// event numbers
`define FDS_EVT_DECODE_QUEUE 8'h79
`define FDS_EVT_FETCH_STALL 8'h80
`define FDS_EVT_FETCH_TAG 8'h83
`define FDS_EVT_FETCH_TLB 8'h85
`define FDS_EVT_LENGTH_PREFIX 8'h87
`define FDS_EVT_UNDELIVERED 8'h9C
`define FDS_EVT_DISPATCH 8'hA1

// unit masks
`define FDS_UM_SEQUENCER 8'h30
`define FDS_UM_FETCH_STALL 8'h04
`define FDS_UM_TAG_HIT 8'h01
`define FDS_UM_TAG_MISS 8'h02
`define FDS_UM_WALK_START 8'h01
`define FDS_UM_WALK_DONE 8'h0E
`define FDS_UM_WALK_BUSY 8'h10
`define FDS_UM_L2_TLB_HIT 8'h20
`define FDS_UM_LENGTH_PREFIX 8'h01
`define FDS_UM_UNDELIVERED 8'h01

// AHB encodings
`define FDS_HTRANS_NONSEQ_BIT 1
`define FDS_HRESP_OKAY 1'b0

`endif

// ### fds_event_select.v
// decodes event number and unit mask into a per-cycle event count
`timescale 1ns/100ps
`default_nettype none
`include "fds_consts.vh"
module fds_event_select (
  input wire [7:0] evt_num,
  input wire [7:0] umask,
  input wire [2:0] sequencer_uops,
  input wire fetch_stall,
  input wire tag_hit,
  input wire tag_miss,
  input wire walk_start,
  input wire walk_done,
  input wire [2:0] walk_busy,
  input wire l2_tlb_hit,
  input wire prefix_stall,
  input wire [2:0] undelivered_slots,
  input wire rename_stall,
  input wire [7:0] dispatch_ports,
  output reg [3:0] evt_count,
  output reg match
);

  function onehot8;
    input [7:0] v;
    integer i;
    integer n;
    begin
      n = 0;
      for (i = 0; i < 8; i = i + 1) begin
        n = n + v[i];
      end
      onehot8 = (n == 1);
    end
  endfunction

  always @* begin
    evt_count = 4'h0;
    match = 1'b1;
    case ({evt_num, umask})
      {`FDS_EVT_DECODE_QUEUE, `FDS_UM_SEQUENCER}: evt_count = {1'b0, sequencer_uops};
      {`FDS_EVT_FETCH_STALL, `FDS_UM_FETCH_STALL}: evt_count = {3'h0, fetch_stall};
      {`FDS_EVT_FETCH_TAG, `FDS_UM_TAG_HIT}: evt_count = {3'h0, tag_hit};
      {`FDS_EVT_FETCH_TAG, `FDS_UM_TAG_MISS}: evt_count = {3'h0, tag_miss};
      {`FDS_EVT_FETCH_TLB, `FDS_UM_WALK_START}: evt_count = {3'h0, walk_start};
      {`FDS_EVT_FETCH_TLB, `FDS_UM_WALK_DONE}: evt_count = {3'h0, walk_done};
      {`FDS_EVT_FETCH_TLB, `FDS_UM_WALK_BUSY}: evt_count = {1'b0, walk_busy};
      {`FDS_EVT_FETCH_TLB, `FDS_UM_L2_TLB_HIT}: evt_count = {3'h0, l2_tlb_hit};
      {`FDS_EVT_LENGTH_PREFIX, `FDS_UM_LENGTH_PREFIX}: evt_count = {3'h0, prefix_stall};
      // a stalled rename stage forces zero, so negated threshold then counts it
      {`FDS_EVT_UNDELIVERED, `FDS_UM_UNDELIVERED}: begin
        evt_count = rename_stall ? 4'h0 : {1'b0, undelivered_slots};
      end
      default: begin
        if (evt_num == `FDS_EVT_DISPATCH && onehot8(umask)) begin
          evt_count = {3'h0, |(dispatch_ports & umask)};
        end else begin
          match = 1'b0;
        end
      end
    endcase
  end

endmodule // fds_event_select
`default_nettype wire

// ### fds_modifier.v
// threshold, negation and rising-transition stage, registered
`timescale 1ns/100ps
`default_nettype none
module fds_modifier #(
  parameter CW = 4
) (
  input wire clk,
  input wire rst_b,
  input wire enable,
  input wire [CW-1:0] evt_count,
  input wire [3:0] threshold,
  input wire negated,
  input wire rising,
  output reg [CW-1:0] inc,
  output reg cond
);

  wire plain_mode;
  wire [3:0] thr_eff;
  wire [CW+3:0] cnt_ext;
  wire [CW+3:0] thr_ext;
  wire above;
  wire next_cond;
  reg prev_cond;

  // with no threshold the raw count is added, unless a modifier needs a condition
  assign plain_mode = (threshold == 4'h0) && !negated && !rising;
  assign thr_eff = (threshold == 4'h0) ? 4'h1 : threshold;
  // both sides widened to one common width so no replication count can reach zero
  assign cnt_ext = {4'h0, evt_count};
  assign thr_ext = {{CW{1'b0}}, thr_eff};
  assign above = (cnt_ext >= thr_ext);
  assign next_cond = negated ? !above : above;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      inc <= {CW{1'b0}};
      cond <= 1'b0;
      prev_cond <= 1'b0;
    end else begin
      cond <= next_cond;
      prev_cond <= enable ? next_cond : 1'b0;
      if (!enable) begin
        inc <= {CW{1'b0}};
      end else if (plain_mode) begin
        inc <= evt_count;
      end else if (rising) begin
        inc <= {{(CW-1){1'b0}}, next_cond && !prev_cond};
      end else begin
        inc <= {{(CW-1){1'b0}}, next_cond};
      end
    end
  end

endmodule // fds_modifier
`default_nettype wire

// ### fds_selector_top.v
// front-end and dispatch event selector with AHB-Lite register slave
`timescale 1ns/100ps
`default_nettype none
`include "fds_consts.vh"
module fds_selector_top #(
  parameter PMH_W = 3
) (
  input wire CLK_SYS,
  input wire RST_B,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output reg [31:0] HRDATA,
  output reg HREADYOUT,
  output reg HRESP,
  input wire [2:0] MICROCODE_SEQUENCER_UOPS,
  input wire FETCH_DATA_STALL,
  input wire FETCH_TAG_LOOKUP_HIT,
  input wire FETCH_TAG_LOOKUP_MISS,
  input wire INSTRUCTION_FETCH_TLB_WALK_START,
  input wire INSTRUCTION_FETCH_TLB_WALK_DONE,
  input wire [PMH_W-1:0] PAGE_MISS_HANDLER_BUSY,
  input wire SECOND_LEVEL_TLB_HIT,
  input wire LENGTH_CHANGING_PREFIX_STALL,
  input wire [2:0] UNDELIVERED_ISSUE_SLOTS,
  input wire RENAME_STAGE_STALL,
  input wire [7:0] DISPATCH_PORTS,
  output reg [3:0] EVENT_INC
);

  reg [`FDS_SEL_USED_MSB:0] select;
  reg [31:0] count;
  reg wr_pend;
  reg rd_pend;
  reg [7:0] addr_q;
  reg [3:0] last_count;
  reg last_match;
  reg [31:0] next_rdata;

  wire accept;
  wire [3:0] evt_count;
  wire match;
  wire [3:0] inc;
  wire cond;
  wire [2:0] walk_busy;
  wire en_eff;

  function [31:0] reg_read;
    input [7:0] a;
    input [`FDS_SEL_USED_MSB:0] sel;
    input [31:0] cnt;
    input mt;
    input cd;
    input [3:0] lc;
    begin
      case (a)
        `FDS_OFS_SELECT: reg_read = {{(31 - `FDS_SEL_USED_MSB){1'b0}}, sel};
        `FDS_OFS_COUNT: reg_read = cnt;
        `FDS_OFS_STATUS: reg_read = {24'h0000_00, lc, 2'b00, cd, mt};
        default: reg_read = 32'h0000_0000;
      endcase
    end
  endfunction

  // busy handler count is clipped to the 3-bit event count range
  generate
    if (PMH_W > 3) begin : g_pmh_wide
      assign walk_busy = (|PAGE_MISS_HANDLER_BUSY[PMH_W-1:3]) ? 3'h7 : PAGE_MISS_HANDLER_BUSY[2:0];
    end else if (PMH_W == 3) begin : g_pmh_exact
      assign walk_busy = PAGE_MISS_HANDLER_BUSY;
    end else begin : g_pmh_narrow
      assign walk_busy = {{(3 - PMH_W){1'b0}}, PAGE_MISS_HANDLER_BUSY};
    end
  endgenerate

  // only single-word transfers are expected; other sizes are taken as words
  assign accept = HSEL && HREADY && HTRANS[`FDS_HTRANS_NONSEQ_BIT];

  fds_event_select u_select (
    .evt_num(select[`FDS_SEL_EVT_MSB:`FDS_SEL_EVT_LSB]),
    .umask(select[`FDS_SEL_UMASK_MSB:`FDS_SEL_UMASK_LSB]),
    .sequencer_uops(MICROCODE_SEQUENCER_UOPS),
    .fetch_stall(FETCH_DATA_STALL),
    .tag_hit(FETCH_TAG_LOOKUP_HIT),
    .tag_miss(FETCH_TAG_LOOKUP_MISS),
    .walk_start(INSTRUCTION_FETCH_TLB_WALK_START),
    .walk_done(INSTRUCTION_FETCH_TLB_WALK_DONE),
    .walk_busy(walk_busy),
    .l2_tlb_hit(SECOND_LEVEL_TLB_HIT),
    .prefix_stall(LENGTH_CHANGING_PREFIX_STALL),
    .undelivered_slots(UNDELIVERED_ISSUE_SLOTS),
    .rename_stall(RENAME_STAGE_STALL),
    .dispatch_ports(DISPATCH_PORTS),
    .evt_count(evt_count),
    .match(match)
  );

  assign en_eff = select[`FDS_SEL_EN_BIT] && match;

  fds_modifier #(
    .CW(4)
  ) u_modifier (
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .enable(en_eff),
    .evt_count(evt_count),
    .threshold(select[`FDS_SEL_THR_MSB:`FDS_SEL_THR_LSB]),
    .negated(select[`FDS_SEL_NEG_BIT]),
    .rising(select[`FDS_SEL_EDGE_BIT]),
    .inc(inc),
    .cond(cond)
  );

  // bus slave: writes finish with no wait, reads take one wait state
  // so that a write just ahead of a read is always seen by it
  always @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      addr_q <= 8'h00;
      HREADYOUT <= 1'b1;
      HRESP <= `FDS_HRESP_OKAY;
      HRDATA <= 32'h0000_0000;
    end else begin
      HRESP <= `FDS_HRESP_OKAY;
      if (rd_pend) begin
        rd_pend <= 1'b0;
        HREADYOUT <= 1'b1;
        HRDATA <= next_rdata;
      end else if (accept) begin
        addr_q <= {HADDR[7:2], 2'b00};
        wr_pend <= HWRITE;
        rd_pend <= !HWRITE;
        HREADYOUT <= HWRITE;
      end else begin
        wr_pend <= 1'b0;
      end
      if (wr_pend && !accept) begin
        wr_pend <= 1'b0;
      end
    end
  end

  always @* begin
    next_rdata = reg_read(addr_q, select, count, last_match, cond, last_count);
  end

  // registers; a software load of the count wins over a same-cycle increment
  always @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      select <= `FDS_SELECT_RST;
      count <= `FDS_COUNT_RST;
      last_count <= 4'h0;
      last_match <= 1'b0;
      EVENT_INC <= 4'h0;
    end else begin
      last_count <= evt_count;
      last_match <= match;
      EVENT_INC <= inc;
      if (wr_pend && addr_q == `FDS_OFS_SELECT) begin
        select <= HWDATA[`FDS_SEL_USED_MSB:0];
      end
      if (wr_pend && addr_q == `FDS_OFS_COUNT) begin
        count <= HWDATA;
      end else begin
        count <= count + {28'h000_0000, inc};
      end
    end
  end

endmodule // fds_selector_top
`default_nettype wire

// ### fds_chk.sv
// port-level assertions for the event selector
`timescale 1ns/100ps
`default_nettype none
module fds_chk #(
  parameter PMH_W = 3
) (
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADYOUT,
  input wire logic FETCH_DATA_STALL,
  input wire logic [PMH_W-1:0] PAGE_MISS_HANDLER_BUSY,
  input wire logic [2:0] UNDELIVERED_ISSUE_SLOTS,
  input wire logic RENAME_STAGE_STALL,
  input wire logic [7:0] DISPATCH_PORTS,
  input wire logic [3:0] EVENT_INC
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  // shadow of the select word; age waits out the registered match and count stages
  logic wp;
  logic [22:0] sel;
  logic [2:0] age;
  wire logic tk = HSEL && HREADYOUT && HTRANS[1];
  wire logic st = age == 3'h7;
  wire logic pl = st && sel[22:16] == 7'h40;
  always @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      wp <= 1'b0;
      sel <= 23'h0;
      age <= 3'h0;
    end else begin
      wp <= tk && HWRITE && HADDR[7:2] == 6'h0;
      if (wp) sel <= HWDATA[22:0];
      age <= wp ? 3'h0 : (st ? age : age + 3'h1);
    end
  end
  a_stall_count: assert property (pl && sel[15:0] == 16'h0480 |-> EVENT_INC == $past(FETCH_DATA_STALL, 2))
    else $error("stall cycles miscounted");
  a_busy_walkers: assert property (pl && sel[15:0] == 16'h1085 |-> EVENT_INC == $past(PAGE_MISS_HANDLER_BUSY, 2))
    else $error("busy walkers miscounted");
  a_slots_free: assert property (pl && sel[15:0] == 16'h019C |->
    EVENT_INC == ($past(RENAME_STAGE_STALL, 2) ? 3'h0 : $past(UNDELIVERED_ISSUE_SLOTS, 2)))
    else $error("undelivered slots miscounted");
  a_port_cycles: assert property (pl && sel[7:0] == 8'hA1 && $onehot(sel[15:8]) |->
    EVENT_INC == |($past(DISPATCH_PORTS, 2) & sel[15:8]))
    else $error("port dispatch miscounted");
  a_full_slots: assert property (st && sel == 23'h44_019C |->
    EVENT_INC == (!$past(RENAME_STAGE_STALL, 2) && $past(UNDELIVERED_ISSUE_SLOTS, 2) == 3'h4))
    else $error("empty issue cycles miscounted");
  a_no_match: assert property (st && (!sel[22] || sel[15:0] == 16'h0379) |-> EVENT_INC == 4'h0)
    else $error("increment on unmatched selection");
  a_read_wait: assert property (tk && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read wait state wrong");
  a_write_nowait: assert property (tk && HWRITE |=> HREADYOUT)
    else $error("write stalled");
  c_stall: cover property (pl && sel[15:0] == 16'h0480 && EVENT_INC == 4'h1);
  c_read: cover property (tk && !HWRITE);
  c_edge: cover property (st && sel[20] && EVENT_INC == 4'h1);
endmodule // fds_chk
`default_nettype wire

// ### fds_core_model.sv
// random core pipeline event source
`timescale 1ns/100ps
`default_nettype none
module fds_core_model (
  input wire logic clk,
  input wire logic run,
  output logic [2:0] uops,
  output logic stl,
  output logic thit,
  output logic tmis,
  output logic wst,
  output logic wdn,
  output logic [2:0] busy,
  output logic l2h,
  output logic lcp,
  output logic [2:0] und,
  output logic ren,
  output logic [7:0] dp
);
  integer seed = 51590;
  logic [31:0] v;
  initial {uops, stl, thit, tmis, wst, wdn, busy, l2h, lcp, und, ren, dp} = 0;
  // slot and uop counts stay within 0..4, the width of the issue stage
  always @(posedge clk) begin
    v = run ? $random(seed) : 32'h0;
    uops <= v[2:0] % 3'h5;
    und <= v[5:3] % 3'h5;
    busy <= v[8:6];
    {stl, thit, tmis, wst, wdn, l2h, lcp} <= v[15:9];
    ren <= v[16] & v[17];
    dp <= v[31:24];
  end
endmodule // fds_core_model
`default_nettype wire

// ### fds_selector_top_bench.sv
// self-checking bench for the event selector
`timescale 1ns/100ps
`default_nettype none
module fds_selector_top_bench;
  logic CLK_SYS = 1'b0;
  logic RST_B = 1'b0;
  logic HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0] HTRANS = 2'h0;
  logic HWRITE = 1'b0;
  logic [31:0] HWDATA = 32'h0;
  logic run = 1'b0;
  logic chk_on = 1'b0;
  wire [31:0] HRDATA;
  wire HREADYOUT;
  wire HRESP;
  wire [3:0] EVENT_INC;
  wire [2:0] uops, busy, und;
  wire stl, thit, tmis, wst, wdn, l2h, lcp, ren;
  wire [7:0] dp;
  logic [22:0] cs;
  logic [31:0] r;
  int err_total = 0;
  int num_checks = 0;
  int acc, prv, i, x, c, e;
  int q[$];
  logic [22:0] cfg [20] = '{
    23'h50_3079, 23'h41_3079, 23'h40_3079, 23'h40_0480, 23'h40_0183,
    23'h40_0283, 23'h40_0185, 23'h40_0E85, 23'h40_1085, 23'h40_2085,
    23'h40_0187, 23'h40_019C, 23'h44_019C, 23'h43_019C, 23'h42_019C,
    23'h61_019C, 23'h71_019C, 23'h40_0379, 23'h40_03A1, 23'h00_0480};
  always #50 CLK_SYS = ~CLK_SYS;
  fds_selector_top fds_selector_top_inst (.CLK_SYS, .RST_B, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2),
    .HWDATA, .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .MICROCODE_SEQUENCER_UOPS(uops),
    .FETCH_DATA_STALL(stl), .FETCH_TAG_LOOKUP_HIT(thit), .FETCH_TAG_LOOKUP_MISS(tmis),
    .INSTRUCTION_FETCH_TLB_WALK_START(wst), .INSTRUCTION_FETCH_TLB_WALK_DONE(wdn),
    .PAGE_MISS_HANDLER_BUSY(busy), .SECOND_LEVEL_TLB_HIT(l2h), .LENGTH_CHANGING_PREFIX_STALL(lcp),
    .UNDELIVERED_ISSUE_SLOTS(und), .RENAME_STAGE_STALL(ren), .DISPATCH_PORTS(dp), .EVENT_INC);
  fds_core_model fds_core_model_inst (.clk(CLK_SYS), .run, .uops, .stl, .thit, .tmis, .wst, .wdn,
    .busy, .l2h, .lcp, .und, .ren, .dp);
  function automatic int raw(input logic [22:0] s);
    case (s[15:0])
      16'h3079: return uops;
      16'h0480: return stl;
      16'h0183: return thit;
      16'h0283: return tmis;
      16'h0185: return wst;
      16'h0E85: return wdn;
      16'h1085: return busy;
      16'h2085: return l2h;
      16'h0187: return lcp;
      16'h019C: return ren ? 0 : und;
      default: return (s[7:0] == 8'hA1 && $onehot(s[15:8])) ? |(dp & s[15:8]) : -1;
    endcase
  endfunction
  function automatic int cnd(input int v);
    int t;
    t = (cs[19:16] == 4'h0) ? 1 : cs[19:16];
    return cs[21] ? v < t : v >= t;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run;
    if (err_total == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_SYS);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= {24'h0, a};
    HWRITE <= w;
    do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HSEL <= 1'b0;
    HWDATA <= d;
    do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
    r = HRDATA;
    chk("hresp", {31'h0, HRESP}, 32'h0);
  endtask
  // the increment lags the driven events by two edges
  always @(negedge CLK_SYS) begin
    if (chk_on) begin
      x = raw(cs);
      if (x < 0 || !cs[22]) e = 0;
      else if (cs[21:16] == 6'h0) e = x;
      else begin
        c = cnd(x);
        e = (cs[20] && prv) ? 0 : c;
        prv = c;
      end
      acc += e;
      q.push_back(e);
      if (q.size() == 3) chk("event_inc", EVENT_INC, q.pop_front());
    end
  end
  task automatic run_cfg(input logic [22:0] s);
    cs = s;
    bus(1'b1, 8'h00, {9'h1FF, s});
    bus(1'b1, 8'h04, 32'h0);
    bus(1'b0, 8'h00, 32'h0);
    chk("select", r, {9'h0, s});
    bus(1'b0, 8'h08, 32'h0);
    chk("match", r[0], raw(s) >= 0);
    chk("cond", r[1], cnd(0));
    chk("last_count", r[7:4], 4'h0);
    q.delete();
    prv = cnd(0);
    acc = 0;
    chk_on = 1'b1;
    run <= 1'b1;
    repeat (40) @(posedge CLK_SYS);
    run <= 1'b0;
    repeat (3) @(posedge CLK_SYS);
    chk_on = 1'b0;
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b0, 8'h04, 32'h0);
    if (!s[21]) chk("count", r, acc);
  endtask
  initial begin
    repeat (16) @(posedge CLK_SYS);
    RST_B <= 1'b1;
    bus(1'b0, 8'h00, 32'h0);
    chk("select_rst", r, 32'h0);
    bus(1'b0, 8'h04, 32'h0);
    chk("count_rst", r, 32'h0);
    bus(1'b1, 8'h0C, 32'hFFFF_FFFF);
    bus(1'b0, 8'h0C, 32'h0);
    chk("unmapped", r, 32'h0);
    bus(1'b1, 8'h04, 32'h1234_5678);
    bus(1'b0, 8'h04, 32'h0);
    chk("count_load", r, 32'h1234_5678);
    foreach (cfg[k]) run_cfg(cfg[k]);
    for (i = 0; i < 8; i++) run_cfg(23'h40_00A1 | (23'h100 << i));
    complete_run;
  end
  initial begin
    repeat (20000) @(posedge CLK_SYS);
    err_total++;
    complete_run;
  end
endmodule // fds_selector_top_bench
bind fds_selector_top fds_chk #(.PMH_W(PMH_W)) fds_chk_inst (.CLK_SYS, .RST_B, .HSEL, .HADDR, .HTRANS,
  .HWRITE, .HWDATA, .HREADYOUT, .FETCH_DATA_STALL, .PAGE_MISS_HANDLER_BUSY, .UNDELIVERED_ISSUE_SLOTS,
  .RENAME_STAGE_STALL, .DISPATCH_PORTS, .EVENT_INC);
`default_nettype wire
